// ### hw/crf_addr_align.sv
// Purpose: Effective address window and even alignment
// Assumes: Purely combinational; caller registers the result
// Notes:   Byte data accesses keep bit 0, all others force it low

`timescale 1ns/1ns

module crf_addr_align (
    input  wire logic              [23:0] ea,
    input  wire crf_pkg::crf_size_t       size,
    input  wire logic                     fetch,
    input  wire logic                     adv_mode,
    output logic                   [23:0] addr
);
    import crf_pkg::*;

    // Word, longword and fetch accesses never fault, they just drop bit 0
    wire        force_even = fetch || (size != CRF_SZ_B);
    wire [23:0] window     = adv_mode ? ADDR_MASK_ADV : ADDR_MASK_NORMAL;
    wire [23:0] even_mask  = force_even ? ADDR_EVEN_MASK : 24'hFFFFFF;

    assign addr = ea & window & even_mask;

endmodule

// ### hw/crf_gpr_mem.sv
// Purpose: Eight 32-bit general registers stored as four byte lanes
// Assumes: One write port with byte enables, one registered read port
// Notes:   Array has no reset; stack pointer copy forwards same-cycle writes

`timescale 1ns/1ns

module crf_gpr_mem (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        we,
    input  wire logic [2:0]  widx,
    input  wire logic [3:0]  wbe,
    input  wire logic [31:0] wdata,
    input  wire logic [2:0]  ridx,
    input  wire logic [1:0]  rsh,
    input  wire logic [31:0] rmask,
    output logic      [31:0] rdata,
    output logic      [31:0] sp_word
);
    import crf_pkg::*;

    logic [31:0] rword;
    wire         sp_hit = we && (widx == SP_IDX);

    // ------------------------------------------------------------------
    // Byte lanes
    // ------------------------------------------------------------------
    // Separate lane arrays so only the enabled bytes ever change
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        logic [7:0] lane_q [GPR_COUNT];
        always_ff @(posedge clk) begin
            if (we && wbe[i]) begin
                lane_q[widx] <= wdata[8*i +: 8];
            end
        end
        assign rword[8*i +: 8] = lane_q[ridx];
        // Stack pointer copy sees a write to its own lane at once
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                sp_word[8*i +: 8] <= 8'h00;
            end else begin
                sp_word[8*i +: 8] <= (sp_hit && wbe[i]) ? wdata[8*i +: 8] : lane_q[SP_IDX];
            end
        end
    end

    // ------------------------------------------------------------------
    // Registered view read
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= (rword >> {rsh, 3'h0}) & rmask;
        end
    end

endmodule

// ### hw/crf_pkg.sv
// Purpose: Shared constants and types for the CPU register file block
// Assumes: Single 20 MHz clock domain
// Notes:   Bit positions, reset values and encodings live here only

package crf_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int GPR_COUNT = 8;
    localparam int GPR_W     = 32;
    localparam int PC_W      = 24;
    localparam int CCR_W     = 8;
    localparam int LANES     = 4;
    localparam logic [2:0] SP_IDX = 3'h7;

    // ------------------------------------------------------------------
    // Condition flags layout
    // ------------------------------------------------------------------
    localparam int CCR_I  = 7;
    localparam int CCR_UI = 6;
    localparam int CCR_H  = 5;
    localparam int CCR_U  = 4;
    localparam int CCR_N  = 3;
    localparam int CCR_Z  = 2;
    localparam int CCR_V  = 1;
    localparam int CCR_C  = 0;
    localparam logic [CCR_W-1:0] CCR_RST      = 8'h80;
    localparam logic [CCR_W-1:0] CCR_ALU_MASK = 8'h2F;

    // Half-carry positions per size; after left alignment all meet one bit
    localparam int HC_BIT_B   = 3;
    localparam int HC_BIT_W   = 11;
    localparam int HC_BIT_L   = 27;
    localparam int HC_ALIGNED = HC_BIT_L + 1;
    localparam logic [4:0] SH_B = 5'(GPR_W - 8);
    localparam logic [4:0] SH_W = 5'(GPR_W - 16);
    localparam logic [4:0] SH_L = 5'h00;

    // ------------------------------------------------------------------
    // Address windows and stack steps
    // ------------------------------------------------------------------
    localparam logic [PC_W-1:0]  ADDR_MASK_NORMAL = 24'h00FFFF;
    localparam logic [PC_W-1:0]  ADDR_MASK_ADV    = 24'h0FFFFF;
    localparam logic [PC_W-1:0]  ADDR_EVEN_MASK   = 24'hFFFFFE;
    localparam logic [PC_W-1:0]  PC_STEP          = 24'h000002;
    localparam logic [GPR_W-1:0] SP_STEP_W        = 32'h00000002;
    localparam logic [GPR_W-1:0] SP_STEP_L        = 32'h00000004;
    localparam int SYNC_STAGES = 3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CRF_SZ_B = 2'h0,
        CRF_SZ_W = 2'h1,
        CRF_SZ_L = 2'h2
    } crf_size_t;

    typedef enum logic [2:0] {
        CRF_ALU_ADD   = 3'h0,
        CRF_ALU_SUB   = 3'h1,
        CRF_ALU_LOGIC = 3'h2,
        CRF_ALU_SHIFT = 3'h3,
        CRF_ALU_BIT   = 3'h4
    } crf_alu_t;

    typedef enum logic [1:0] {
        CRF_CTL_LOAD = 2'h0,
        CRF_CTL_AND  = 2'h1,
        CRF_CTL_OR   = 2'h2,
        CRF_CTL_XOR  = 2'h3
    } crf_ctl_t;

    typedef enum logic [3:0] {
        CRF_CC_T  = 4'h0,
        CRF_CC_F  = 4'h1,
        CRF_CC_HI = 4'h2,
        CRF_CC_LS = 4'h3,
        CRF_CC_CC = 4'h4,
        CRF_CC_CS = 4'h5,
        CRF_CC_NE = 4'h6,
        CRF_CC_EQ = 4'h7,
        CRF_CC_VC = 4'h8,
        CRF_CC_VS = 4'h9,
        CRF_CC_PL = 4'hA,
        CRF_CC_MI = 4'hB,
        CRF_CC_GE = 4'hC,
        CRF_CC_LT = 4'hD,
        CRF_CC_GT = 4'hE,
        CRF_CC_LE = 4'hF
    } crf_cond_t;

    typedef enum logic [1:0] {
        CRF_ST_VEC = 2'h1,
        CRF_ST_RUN = 2'h2
    } crf_state_t;

endpackage

// ### hw/crf_regs.sv
// Purpose: CPU programmer-visible state: general registers, PC, flags
// Assumes: Same-clock decode logic drives requests; mode pin is async
// Notes:   Flags other than I come out of reset at zero

`timescale 1ns/1ns

module crf_regs (
    input  wire logic                     clk,
    input  wire logic                     rstn,
    input  wire logic              [23:0] reset_vector,
    input  wire logic                     adv_mode_pin,
    input  wire logic                     gpr_wr_en,
    input  wire logic               [2:0] gpr_wr_idx,
    input  wire crf_pkg::crf_size_t       gpr_wr_size,
    input  wire logic                     gpr_wr_part,
    input  wire logic              [31:0] gpr_wr_data,
    input  wire logic               [2:0] gpr_rd_idx,
    input  wire crf_pkg::crf_size_t       gpr_rd_size,
    input  wire logic                     gpr_rd_part,
    input  wire logic                     sp_adj_en,
    input  wire logic                     sp_adj_push,
    input  wire crf_pkg::crf_size_t       sp_adj_size,
    input  wire logic                     pc_load,
    input  wire logic              [23:0] pc_load_val,
    input  wire logic                     pc_inc,
    input  wire logic                     acc_req,
    input  wire logic              [23:0] acc_ea,
    input  wire crf_pkg::crf_size_t       acc_size,
    input  wire logic                     alu_valid,
    input  wire crf_pkg::crf_alu_t        alu_kind,
    input  wire crf_pkg::crf_size_t       alu_size,
    input  wire logic              [31:0] alu_a,
    input  wire logic              [31:0] alu_b,
    input  wire logic                     alu_cin,
    input  wire logic               [7:0] flag_upd_mask,
    input  wire logic                     ctl_en,
    input  wire crf_pkg::crf_ctl_t        ctl_op,
    input  wire logic               [7:0] ctl_data,
    input  wire logic                     exc_start,
    input  wire logic                     irq_req,
    input  wire logic                     nmi_req,
    input  wire crf_pkg::crf_cond_t       cond_code,
    output logic                   [31:0] gpr_rd_data,
    output logic                   [31:0] stack_pointer,
    output logic                   [23:0] program_counter,
    output logic                   [23:0] fetch_addr,
    output logic                   [23:0] acc_addr,
    output logic                    [7:0] condition_flags,
    output logic                          int_accept,
    output logic                          branch_taken,
    output logic                          adv_mode,
    output logic                          ready
);
    import crf_pkg::*;

    crf_state_t state_q;
    crf_state_t state_d;
    logic [SYNC_STAGES-1:0] mode_sync_q;
    logic [23:0] pc_d;
    logic [23:0] fetch_addr_d;
    logic [23:0] acc_addr_d;
    logic [7:0]  ccr_d;
    logic [7:0]  alu_flags;
    logic        cond_true;

    // ------------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------------
    // One cycle of vector load after reset, then normal operation
    wire run = (state_q == CRF_ST_RUN);
    assign state_d = CRF_ST_RUN;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= CRF_ST_VEC;
            ready   <= 1'b0;
        end else begin
            case (state_q)
                CRF_ST_VEC: state_q <= state_d;
                CRF_ST_RUN: state_q <= state_d;
                default:    state_q <= CRF_ST_VEC;
            endcase
            ready <= (state_d == CRF_ST_RUN);
        end
    end

    // ------------------------------------------------------------------
    // Mode pin synchroniser
    // ------------------------------------------------------------------
    // Third stage must agree with the second before the mode moves
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_sync_q <= 3'h0;
            adv_mode    <= 1'b0;
        end else begin
            mode_sync_q <= {mode_sync_q[SYNC_STAGES-2:0], adv_mode_pin};
            if (mode_sync_q[1] == mode_sync_q[2]) begin
                adv_mode <= mode_sync_q[2];
            end
        end
    end

    // ------------------------------------------------------------------
    // General register write path
    // ------------------------------------------------------------------
    // Views pick byte lanes; data always arrives right-justified
    wire gpr_we_ok = run && gpr_wr_en;
    wire sp_we_ok  = run && sp_adj_en && !gpr_wr_en;

    wire [3:0] wbe_word = gpr_wr_part ? 4'hC : 4'h3;
    wire [3:0] wbe_byte = gpr_wr_part ? 4'h2 : 4'h1;
    wire [3:0] view_be  = (gpr_wr_size == CRF_SZ_L) ? 4'hF :
                          (gpr_wr_size == CRF_SZ_W) ? wbe_word : wbe_byte;

    wire [31:0] view_data = (gpr_wr_size == CRF_SZ_L) ? gpr_wr_data :
                            (gpr_wr_size == CRF_SZ_W) ? {2{gpr_wr_data[15:0]}} :
                            {4{gpr_wr_data[7:0]}};

    // Stack step uses the forwarded copy, so pushes may run back to back
    wire [31:0] sp_step = (sp_adj_size == CRF_SZ_L) ? SP_STEP_L : SP_STEP_W;
    wire [31:0] sp_next = sp_adj_push ? (stack_pointer - sp_step)
                                      : (stack_pointer + sp_step);

    wire        mem_we    = gpr_we_ok || sp_we_ok;
    wire [2:0]  mem_widx  = gpr_we_ok ? gpr_wr_idx : SP_IDX;
    wire [3:0]  mem_wbe   = gpr_we_ok ? view_be : 4'hF;
    wire [31:0] mem_wdata = gpr_we_ok ? view_data : sp_next;

    // ------------------------------------------------------------------
    // General register read view
    // ------------------------------------------------------------------
    wire [1:0]  rsh_word = gpr_rd_part ? 2'h2 : 2'h0;
    wire [1:0]  rsh_byte = gpr_rd_part ? 2'h1 : 2'h0;
    wire [1:0]  rd_sh    = (gpr_rd_size == CRF_SZ_L) ? 2'h0 :
                           (gpr_rd_size == CRF_SZ_W) ? rsh_word : rsh_byte;
    wire [31:0] rd_mask  = (gpr_rd_size == CRF_SZ_L) ? 32'hFFFFFFFF :
                           (gpr_rd_size == CRF_SZ_W) ? 32'h0000FFFF : 32'h000000FF;

    crf_gpr_mem u_mem (
        .clk     (clk),
        .rstn    (rstn),
        .we      (mem_we),
        .widx    (mem_widx),
        .wbe     (mem_wbe),
        .wdata   (mem_wdata),
        .ridx    (gpr_rd_idx),
        .rsh     (rd_sh),
        .rmask   (rd_mask),
        .rdata   (gpr_rd_data),
        .sp_word (stack_pointer)
    );

    // ------------------------------------------------------------------
    // Program counter and addresses
    // ------------------------------------------------------------------
    // Load beats increment; the vector is caught one edge after release
    assign pc_d = !run    ? reset_vector :
                  pc_load ? pc_load_val :
                  pc_inc  ? (program_counter + PC_STEP) : program_counter;

    crf_addr_align u_fetch_align (
        .ea       (pc_d),
        .size     (CRF_SZ_W),
        .fetch    (1'b1),
        .adv_mode (adv_mode),
        .addr     (fetch_addr_d)
    );

    crf_addr_align u_acc_align (
        .ea       (acc_ea),
        .size     (acc_size),
        .fetch    (1'b0),
        .adv_mode (adv_mode),
        .addr     (acc_addr_d)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            program_counter <= 24'h000000;
            fetch_addr      <= 24'h000000;
            acc_addr        <= 24'h000000;
        end else begin
            program_counter <= pc_d;
            fetch_addr      <= fetch_addr_d;
            if (acc_req && run) begin
                acc_addr <= acc_addr_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // Flag computation
    // ------------------------------------------------------------------
    // Operands are left aligned so one adder and one half-carry tap
    // serve all sizes; bits below the operand are zero and carry nothing.
    wire [4:0] al_sh = (alu_size == CRF_SZ_B) ? SH_B :
                       (alu_size == CRF_SZ_W) ? SH_W : SH_L;
    wire is_sub   = (alu_kind == CRF_ALU_SUB);
    wire is_arith = is_sub || (alu_kind == CRF_ALU_ADD);
    wire c_take   = (alu_kind == CRF_ALU_SHIFT) || (alu_kind == CRF_ALU_BIT);

    wire [31:0] a_al = alu_a << al_sh;
    wire [31:0] b_al = (is_sub ? ~alu_b : alu_b) << al_sh;
    wire [31:0] c_al = {31'h00000000, alu_cin ^ is_sub} << al_sh;
    wire [32:0] sum  = {1'b0, a_al} + {1'b0, b_al} + {1'b0, c_al};
    wire [31:0] res  = is_arith ? sum[31:0] : a_al;

    wire hc = (a_al[HC_ALIGNED] ^ b_al[HC_ALIGNED] ^ sum[HC_ALIGNED]) ^ is_sub;
    wire ov = is_arith && (a_al[31] == b_al[31]) && (sum[31] != a_al[31]);
    wire cy = is_arith ? (sum[32] ^ is_sub) : alu_cin;

    always_comb begin
        alu_flags        = condition_flags;
        alu_flags[CCR_H] = is_arith ? hc : condition_flags[CCR_H];
        alu_flags[CCR_N] = res[31];
        alu_flags[CCR_Z] = (res == 32'h00000000);
        alu_flags[CCR_V] = ov;
        alu_flags[CCR_C] = (is_arith || c_take) ? cy : condition_flags[CCR_C];
    end

    // ------------------------------------------------------------------
    // Condition flags register
    // ------------------------------------------------------------------
    // Control writes win over arithmetic; exception entry wins for I
    wire [7:0] alu_wmask = alu_valid ? (flag_upd_mask & CCR_ALU_MASK) : 8'h00;
    wire [7:0] ccr_alu   = (condition_flags & ~alu_wmask) | (alu_flags & alu_wmask);
    wire [7:0] ctl_val   = (ctl_op == CRF_CTL_LOAD) ? ctl_data :
                           (ctl_op == CRF_CTL_AND)  ? (condition_flags & ctl_data) :
                           (ctl_op == CRF_CTL_OR)   ? (condition_flags | ctl_data) :
                           (condition_flags ^ ctl_data);
    wire [7:0] ccr_upd   = ctl_en ? ctl_val : ccr_alu;

    always_comb begin
        ccr_d = run ? ccr_upd : condition_flags;
        if (run && exc_start) begin
            ccr_d[CCR_I] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            condition_flags <= CCR_RST;
        end else begin
            condition_flags <= ccr_d;
        end
    end

    // ------------------------------------------------------------------
    // Branch condition and interrupt gate
    // ------------------------------------------------------------------
    wire fn = condition_flags[CCR_N];
    wire fz = condition_flags[CCR_Z];
    wire fv = condition_flags[CCR_V];
    wire fc = condition_flags[CCR_C];

    always_comb begin
        case (cond_code)
            CRF_CC_T:  cond_true = 1'b1;
            CRF_CC_F:  cond_true = 1'b0;
            CRF_CC_HI: cond_true = !(fc || fz);
            CRF_CC_LS: cond_true = fc || fz;
            CRF_CC_CC: cond_true = !fc;
            CRF_CC_CS: cond_true = fc;
            CRF_CC_NE: cond_true = !fz;
            CRF_CC_EQ: cond_true = fz;
            CRF_CC_VC: cond_true = !fv;
            CRF_CC_VS: cond_true = fv;
            CRF_CC_PL: cond_true = !fn;
            CRF_CC_MI: cond_true = fn;
            CRF_CC_GE: cond_true = !(fn ^ fv);
            CRF_CC_LT: cond_true = fn ^ fv;
            CRF_CC_GT: cond_true = !(fz || (fn ^ fv));
            CRF_CC_LE: cond_true = fz || (fn ^ fv);
            default:   cond_true = 1'b0;
        endcase
    end

    // NMI bypasses the mask; UI masking is left to the interrupt controller
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            branch_taken <= 1'b0;
            int_accept   <= 1'b0;
        end else begin
            branch_taken <= cond_true;
            int_accept   <= nmi_req || (irq_req && !condition_flags[CCR_I]);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    int_gate_a: assert property (irq_req && !nmi_req && condition_flags[CCR_I] |=> !int_accept)
        else $error("maskable interrupt accepted while masked");
    nmi_pass_a: assert property (nmi_req |=> int_accept)
        else $error("nonmaskable interrupt not accepted");
    exc_mask_a: assert property (run && exc_start |=> condition_flags[CCR_I])
        else $error("exception entry left interrupt mask clear");
    reset_state_a: assert property (!run |-> condition_flags[CCR_I] ##1 program_counter == $past(reset_vector))
        else $error("reset did not set mask or load vector");
    // Fetch address is the windowed counter, window as it stood one edge back
    fetch_even_a: assert property (run |-> !fetch_addr[0] &&
            fetch_addr[23:1] == 23'((program_counter & ($past(adv_mode) ? ADDR_MASK_ADV : ADDR_MASK_NORMAL)) >> 1))
        else $error("fetch address not even copy of counter");
    addr_window_a: assert property (!$past(adv_mode) |-> fetch_addr[23:16] == 8'h00)
        else $error("normal mode address beyond 64 kbytes");
    flag_hold_a: assert property (run && !ctl_en && !exc_start |=>
            (condition_flags & ~$past(alu_wmask)) == ($past(condition_flags) & ~$past(alu_wmask)))
        else $error("flag not selected for update changed");
    zero_flag_a: assert property (run && alu_valid && is_arith && flag_upd_mask[CCR_Z] && !ctl_en |=>
            condition_flags[CCR_Z] == ($past(res) == 32'h00000000))
        else $error("zero flag does not match result");
    sp_push_a: assert property (sp_we_ok && sp_adj_push && sp_adj_size == CRF_SZ_L |=>
            stack_pointer == $past(stack_pointer) - SP_STEP_L)
        else $error("longword push did not step stack by four");

endmodule

// ### tb/testbench.sv
// Purpose: Self-checking bench for the CPU register file block
// Assumes: Random stimulus from a fixed seed, corner cases mixed in
// Notes:   Expected values come from bench functions, inline expressions and literals
`timescale 1ns/1ns
module testbench;
    import crf_pkg::*;
    logic clk = 0, rstn = 0, adv_mode_pin = 0, gpr_wr_en = 0, gpr_wr_part = 0, gpr_rd_part = 0;
    logic sp_adj_en = 0, sp_adj_push = 0, pc_load = 0, pc_inc = 0, acc_req = 0, alu_valid = 0;
    logic alu_cin = 0, ctl_en = 0, exc_start = 0, irq_req = 0, nmi_req = 0;
    logic [2:0]  gpr_wr_idx = 0, gpr_rd_idx = 0;
    logic [23:0] reset_vector = 24'h012346, pc_load_val = 0, acc_ea = 0, program_counter, fetch_addr, acc_addr;
    logic [31:0] gpr_wr_data = 0, alu_a = 0, alu_b = 0, gpr_rd_data, stack_pointer, w, r;
    logic [7:0]  flag_upd_mask = 8'hFF, ctl_data = 0, condition_flags, f, d, g;
    logic        int_accept, branch_taken, adv_mode, ready;
    crf_size_t   gpr_wr_size = CRF_SZ_L, gpr_rd_size = CRF_SZ_L, sp_adj_size = CRF_SZ_L;
    crf_size_t   acc_size = CRF_SZ_W, alu_size = CRF_SZ_B;
    crf_alu_t    alu_kind = CRF_ALU_ADD;
    crf_ctl_t    ctl_op = CRF_CTL_LOAD;
    crf_cond_t   cond_code = CRF_CC_NE;
    integer      seed = 19, fail_count = 0, checks = 0, i;
    int          k, kd, j;
    logic        cb;

    crf_regs uut (.*);

    // ----------------------------------------------------------------
    // Clock, watchdog, helpers
    // ----------------------------------------------------------------
    initial forever #25 clk = ~clk;
    // Whole run is a few hundred cycles; this bound only catches a hang
    initial begin
        #200000 fail_count++;
        results();
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic ed(input int n = 1);
        repeat (n) @(posedge clk);
    endtask
    // Flags of an n-bit add (0), subtract (1) or shift (3); I, UI, U never move
    function automatic logic [7:0] arf(int kd, int n, logic [31:0] a, logic [31:0] b, logic c, logic [7:0] p);
        logic [33:0] s, t, m, hm;
        m  = (34'h1 << n) - 34'h1;
        hm = (34'h1 << (n - 4)) - 34'h1;
        s  = (kd == 1) ? (a & m) - (b & m) - c : (a & m) + (b & m) + c;
        t  = (kd == 1) ? (a & hm) - (b & hm) - c : (a & hm) + (b & hm) + c;
        if (kd == 3) return {p[7:4], a[n-1], (a & m) == 34'h0, 1'b0, c};
        return {p[7:6], t[n-4], p[4], s[n-1], (s & m) == 34'h0,
                (a[n-1] ^ kd[0]) == b[n-1] && s[n-1] != a[n-1], s[n]};
    endfunction
    // Branch test on N Z V C; each odd code inverts the even one below it
    function automatic logic cnd(int c, logic [7:0] p);
        logic t;
        case (c / 2)
            0: t = 1'b1;
            1: t = !(p[0] || p[2]);
            2: t = !p[0];
            3: t = !p[2];
            4: t = !p[1];
            5: t = !p[3];
            6: t = !(p[3] ^ p[1]);
            default: t = !(p[2] || (p[3] ^ p[1]));
        endcase
        return t ^ c[0];
    endfunction

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        ed(5);
        chk("flags_rst", condition_flags, 8'h80);
        chk("ready_rst", ready, 1'b0);
        rstn <= 1;
        ed(2);
        #1 chk("pc_vec", program_counter, reset_vector);
        chk("ready", ready, 1'b1);
        // Long write, then high byte and upper half must merge
        for (i = 0; i < 8; i++) begin
            ed();
            w = $random(seed);
            r = $random(seed);
            gpr_wr_en <= 1; gpr_wr_idx <= 3'(i); gpr_wr_size <= CRF_SZ_L; gpr_wr_data <= w;
            ed();
            gpr_wr_size <= CRF_SZ_B; gpr_wr_part <= 1; gpr_wr_data <= r & 32'h000000FF;
            ed();
            gpr_wr_size <= CRF_SZ_W; gpr_wr_data <= r >> 16;
            ed();
            gpr_wr_en <= 0; gpr_rd_idx <= 3'(i);
            ed();
            #1 chk("gpr", gpr_rd_data, {r[31:16], r[7:0], w[7:0]});
            if (i == 7) chk("sp", stack_pointer, {r[31:16], r[7:0], w[7:0]});
            gpr_rd_size <= CRF_SZ_W; gpr_rd_part <= 1;
            ed();
            gpr_rd_size <= CRF_SZ_B;
            #1 chk("gpr_upper", gpr_rd_data, r[31:16]);
            ed();
            gpr_rd_size <= CRF_SZ_L; gpr_rd_part <= 0;
            #1 chk("gpr_high_byte", gpr_rd_data, r[7:0]);
        end
        w = stack_pointer;
        sp_adj_en <= 1; sp_adj_push <= 1;
        ed();
        sp_adj_en <= 0;
        ed();
        #1 chk("sp_push", stack_pointer, w - 32'h00000004);
        w = $random(seed) | 32'h00F10001;
        pc_load <= 1; pc_load_val <= w[23:0];
        ed();
        pc_load <= 0; adv_mode_pin <= 1;
        ed();
        #1 chk("pc", program_counter, w[23:0]);
        chk("fetch_n", fetch_addr, w[23:0] & 24'h00FFFE);
        chk("mode_n", adv_mode, 1'b0);
        pc_inc <= 1;
        ed();
        pc_inc <= 0;
        ed(5);
        #1 chk("fetch_a", fetch_addr, 24'(w[23:0] + 24'h2) & 24'h0FFFFE);
        chk("pc_inc", program_counter, 24'(w[23:0] + 24'h2));
        chk("mode_a", adv_mode, 1'b1);
        for (i = 0; i < 3; i++) begin
            ed();
            acc_req <= 1; acc_ea <= w[23:0]; acc_size <= crf_size_t'(i);
            ed();
            acc_req <= 0;
            ed();
            #1 chk("acc", acc_addr, w[23:0] & (i == 0 ? 24'h0FFFFF : 24'h0FFFFE));
        end
        // Byte, word and long corners first, then random add, subtract, shift
        for (i = 0; i < 31; i++) begin
            ed();
            f = condition_flags;
            w = (i == 0) ? 32'h7F : (i == 1) ? 32'hFF : (i == 2) ? 32'h8000 :
                (i == 3) ? 32'h0FFFFFFF : $random(seed);
            r = (i < 4) ? 32'h1 : $random(seed);
            k = (i < 4) ? i / 2 + (i == 3) : (i / 3) % 3;
            kd = (i == 2) ? 1 : (i < 4) ? 0 : (i % 3 == 2) ? 3 : i % 3;
            cb = (i > 3) & r[3];
            alu_valid <= 1; alu_a <= w; alu_b <= r; alu_cin <= cb;
            alu_size <= crf_size_t'(k); alu_kind <= crf_alu_t'(kd);
            ed();
            alu_valid <= 0;
            ed();
            #1 chk("flags_alu", condition_flags, arf(kd, 8 << k, w, r, cb, f));
        end
        // Control writes through every operator, each branch code on the result
        for (j = 0; j < 16; j++) begin
            f = condition_flags;
            d = 8'($random(seed));
            g = (j % 4 == 0) ? d : (j % 4 == 1) ? (f & d) : (j % 4 == 2) ? (f | d) : (f ^ d);
            ctl_en <= 1; ctl_op <= crf_ctl_t'(j % 4); ctl_data <= d; cond_code <= crf_cond_t'(j);
            ed();
            ctl_en <= 0;
            ed();
            #1 chk("flags_ctl_op", condition_flags, g);
            chk("branch_code", branch_taken, cnd(j, g));
        end
        cond_code <= CRF_CC_NE;
        ctl_en <= 1; ctl_op <= CRF_CTL_LOAD; ctl_data <= 8'h50;
        ed();
        ctl_en <= 0; irq_req <= 1;
        ed();
        #1 chk("flags_ctl", condition_flags, 8'h50);
        exc_start <= 1;
        ed();
        #1 chk("irq_open", int_accept, 1'b1);
        exc_start <= 0;
        ed();
        #1 chk("flags_exc", condition_flags, 8'hD0);
        ed();
        #1 chk("irq_mask", int_accept, 1'b0);
        nmi_req <= 1;
        ed(2);
        #1 chk("nmi", int_accept, 1'b1);
        chk("branch", branch_taken, 1'b1);
        results();
    end
endmodule
